// [shared/spcb_pkg.sv]
// Purpose: Constants for the hart status privilege and context bits block.
// Assumes: APB byte addresses, 32-bit data, one word per register.
// Notes:   Function
// Function
// - With modify-privilege set, data accesses use previous-privilege; fetch keeps current.
// - Modify-privilege reads zero without user mode.
// - Exec-readable clear: loads need readable; set: readable or executable pages.
// - Exec-readable ignored without paging; zero without supervisor mode.
// - Supervisor-user-access clear faults supervisor access to user pages; paging only.
// - Supervisor-user-access also applies with modify-privilege and previous-privilege supervisor.
// - Trap-translation-ops set: supervisor translation register access or fence traps.
// - Trap-translation-ops zero without supervisor mode.
// - Trap-wait set: supervisor wait not done within limit traps illegal.
// - Wait limit may be zero; trap-wait zero without supervisor mode.
// - Trap-supervisor-return set: supervisor return in supervisor mode traps.
// - Two-bit writable fp status and two-bit read-only extension aggregate.
// - Encoding 0 Off, 1 Initial, 2 Clean, 3 Dirty.
// - Fp status zero without supervisor mode and fp unit.
// - Aggregate zero without stateful extensions; each extension has local status.
// - Aggregate reports highest per-extension status.
// - Dirty bit flags dirty in either field; zero if both hardwired.
// - Access to a unit whose status is Off raises an exception.
// - Status fields update as instructions execute in every mode.
// - Software sets fp status directly; aggregate only via extension status writes.
// - Dirty bit is fp status Dirty OR aggregate Dirty.
// - Modifying instruction moves Initial or Clean to Dirty; Off raises exception.
package spcb_pkg;

    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;

    // Register byte offsets
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_FP     = 8'h04;
    localparam logic [7:0]  OFF_EXT    = 8'h08;
    localparam logic [7:0]  OFF_SUMM   = 8'h0c;

    // Control register fields, and the summary register dirty bit
    localparam int          BIT_MPRIV  = 0;
    localparam int          BIT_EXECR  = 1;
    localparam int          BIT_SUACC  = 2;
    localparam int          BIT_TTOPS  = 3;
    localparam int          BIT_TWAIT  = 4;
    localparam int          BIT_TSRET  = 5;
    localparam int          POS_PPRIV  = 8;
    localparam int          BIT_DIRTY  = 31;

    localparam logic [5:0]  CTRL_RESET = 6'h00;
    localparam logic [1:0]  PPRIV_RST  = 2'h0;

    // Privilege codes
    localparam logic [1:0]  PRIV_U     = 2'h0;
    localparam logic [1:0]  PRIV_S     = 2'h1;
    localparam logic [1:0]  PRIV_M     = 2'h3;

    // Unit status codes
    localparam logic [1:0]  ST_OFF     = 2'h0;
    localparam logic [1:0]  ST_INIT    = 2'h1;
    localparam logic [1:0]  ST_CLEAN   = 2'h2;
    localparam logic [1:0]  ST_DIRTY   = 2'h3;

    // Unit operation codes from the pipeline
    localparam logic [2:0]  UOP_NONE   = 3'h0;
    localparam logic [2:0]  UOP_READ   = 3'h1;
    localparam logic [2:0]  UOP_MODIFY = 3'h2;
    localparam logic [2:0]  UOP_UNCONF = 3'h3;
    localparam logic [2:0]  UOP_DISABL = 3'h4;
    localparam logic [2:0]  UOP_ENABLE = 3'h5;

    // Memory access kinds
    localparam logic [1:0]  MEM_LOAD   = 2'h0;
    localparam logic [1:0]  MEM_STORE  = 2'h1;
    localparam logic [1:0]  MEM_FETCH  = 2'h2;

    localparam int          WAIT_LIMIT_DEF = 16;
    localparam int          NUM_EXT_DEF    = 2;

endpackage

// [src/spcb_unit_status.sv]
// Purpose: One unit's Off/Initial/Clean/Dirty status field.
// Assumes: One pipeline op per cycle for this unit.
// Notes:   Hardware ops take priority over a software write in the same cycle.
`timescale 1ns/100ps
module spcb_unit_status #(
    parameter bit HARDWIRED = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic [2:0]  op,
    input  wire logic        sw_we,
    input  wire logic [1:0]  sw_val,
    output logic      [1:0]  status_r,
    output logic             exc
);
    import spcb_pkg::*;

    logic needs_on;

    // ****************************************
    // Off-state use check
    // ****************************************
    always_comb begin
        needs_on = (op == UOP_READ) || (op == UOP_MODIFY) || (op == UOP_UNCONF);
        exc      = needs_on && (status_r == ST_OFF);
    end

    // ****************************************
    // Status update
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= ST_OFF;
        end else if (ce && !HARDWIRED) begin
            if (op == UOP_MODIFY) begin
                if (status_r != ST_OFF) begin
                    status_r <= ST_DIRTY;
                end
            end else if (op == UOP_UNCONF) begin
                if (status_r != ST_OFF) begin
                    status_r <= ST_INIT;
                end
            end else if (op == UOP_DISABL) begin
                status_r <= ST_OFF;
            end else if (op == UOP_ENABLE) begin
                status_r <= ST_INIT;
            end else if (sw_we) begin
                status_r <= sw_val;
            end
        end
    end

endmodule

// [src/spcb_status_ctrl.sv]
// Purpose: Privilege modifiers, virtualization traps and extension context status.
// Assumes: Pipeline inputs are on pclk; APB slave, zero wait states after setup.
// Notes:   Outputs are registered, one cycle after the request that causes them; aggregate and dirty bit two cycles after a unit op.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
module spcb_status_ctrl #(
    parameter bit HAS_USER       = 1'b1,
    parameter bit HAS_SUPER      = 1'b1,
    parameter bit HAS_FPU        = 1'b1,
    parameter bit HAS_EXT_STATE  = 1'b1,
    parameter int NUM_EXT        = spcb_pkg::NUM_EXT_DEF,
    parameter int WAIT_LIMIT     = spcb_pkg::WAIT_LIMIT_DEF
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [spcb_pkg::ADDR_W-1:0] paddr,
    input  wire logic [spcb_pkg::DATA_W-1:0] pwdata,
    output logic      [spcb_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Hart state
    input  wire logic [1:0]                  cur_priv,
    input  wire logic                        vm_active,
    // Memory access check
    input  wire logic                        mem_valid,
    input  wire logic [1:0]                  mem_kind,
    input  wire logic                        pte_read,
    input  wire logic                        pte_write,
    input  wire logic                        pte_exec,
    input  wire logic                        pte_user,
    output logic      [1:0]                  mem_priv_r,
    output logic                             mem_fault_r,
    // Instruction checks
    input  wire logic                        instr_valid,
    input  wire logic                        is_xlat_reg_access,
    input  wire logic                        is_translation_fence_instr,
    input  wire logic                        is_supervisor_return_instr,
    input  wire logic                        wait_interrupt_pending,
    input  wire logic [2:0]                  fp_op,
    input  wire logic [3*NUM_EXT-1:0]        ext_op,
    output logic                             illegal_instr_r,
    // Status view
    output logic                             modify_privilege_bit,
    output logic      [1:0]                  machine_previous_privilege,
    output logic                             exec_readable_bit,
    output logic                             supervisor_user_access_bit,
    output logic                             trap_translation_ops_bit,
    output logic                             trap_wait_bit,
    output logic                             trap_supervisor_return_bit,
    output logic      [1:0]                  fp_state_status,
    output logic      [1:0]                  ext_state_aggregate,
    output logic                             dirty_aggregate_bit
);
    import spcb_pkg::*;

    localparam bit FP_HARD   = !HAS_SUPER && !HAS_FPU;
    localparam bit EXT_HARD  = !HAS_EXT_STATE;
    localparam int CNT_W     = (WAIT_LIMIT > 1) ? $clog2(WAIT_LIMIT + 1) : 1;
    localparam logic [CNT_W-1:0] WAIT_MAX = CNT_W'(WAIT_LIMIT);

    logic                    setup;
    logic                    wr_en;
    logic                    hit_ctrl;
    logic                    hit_fp;
    logic                    hit_ext;
    logic                    hit_summ;
    logic [DATA_W-1:0]       rd_val;
    logic [1:0]              ext_st    [NUM_EXT];
    logic [NUM_EXT-1:0]      ext_exc;
    logic                    fp_exc;
    logic [1:0]              agg_nxt;
    logic [1:0]              data_priv;
    logic [1:0]              acc_priv;
    logic                    fault_nxt;
    logic                    in_super;
    logic                    wait_trap;
    logic                    illegal_nxt;
    logic [CNT_W-1:0]        wait_cnt_r;
    logic                    wait_fired_r;

    // ****************************************
    // APB decode
    // ****************************************
    always_comb begin
        setup    = psel && !penable;
        wr_en    = psel && penable && pready && pwrite;
        hit_ctrl = (paddr == OFF_CTRL);
        hit_fp   = (paddr == OFF_FP);
        hit_ext  = (paddr == OFF_EXT);
        hit_summ = (paddr == OFF_SUMM);
    end

    // Read mux
    always_comb begin
        rd_val = '0;
        if (hit_ctrl) begin
            rd_val[BIT_MPRIV]            = modify_privilege_bit;
            rd_val[BIT_EXECR]            = exec_readable_bit;
            rd_val[BIT_SUACC]            = supervisor_user_access_bit;
            rd_val[BIT_TTOPS]            = trap_translation_ops_bit;
            rd_val[BIT_TWAIT]            = trap_wait_bit;
            rd_val[BIT_TSRET]            = trap_supervisor_return_bit;
            rd_val[POS_PPRIV+1:POS_PPRIV] = machine_previous_privilege;
        end else if (hit_fp) begin
            rd_val[1:0] = fp_state_status;
        end else if (hit_ext) begin
            for (int i = 0; i < NUM_EXT; i++) begin
                rd_val[2*i +: 2] = ext_st[i];
            end
        end else if (hit_summ) begin
            rd_val[1:0]       = ext_state_aggregate;
            rd_val[BIT_DIRTY] = dirty_aggregate_bit;
        end
    end

    // ****************************************
    // APB response
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= setup;
            if (setup) begin
                prdata  <= pwrite ? '0 : rd_val;
                pslverr <= !(hit_ctrl || hit_fp || hit_ext || hit_summ);
            end
        end
    end

    // ****************************************
    // Control bits
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modify_privilege_bit       <= CTRL_RESET[BIT_MPRIV];
            exec_readable_bit          <= CTRL_RESET[BIT_EXECR];
            supervisor_user_access_bit <= CTRL_RESET[BIT_SUACC];
            trap_translation_ops_bit   <= CTRL_RESET[BIT_TTOPS];
            trap_wait_bit              <= CTRL_RESET[BIT_TWAIT];
            trap_supervisor_return_bit <= CTRL_RESET[BIT_TSRET];
            machine_previous_privilege <= PPRIV_RST;
        end else if (ce && wr_en && hit_ctrl) begin
            modify_privilege_bit       <= pwdata[BIT_MPRIV] && HAS_USER;
            exec_readable_bit          <= pwdata[BIT_EXECR] && HAS_SUPER;
            supervisor_user_access_bit <= pwdata[BIT_SUACC] && HAS_SUPER;
            trap_translation_ops_bit   <= pwdata[BIT_TTOPS] && HAS_SUPER;
            trap_wait_bit              <= pwdata[BIT_TWAIT] && HAS_SUPER;
            trap_supervisor_return_bit <= pwdata[BIT_TSRET] && HAS_SUPER;
            machine_previous_privilege <= pwdata[POS_PPRIV+1:POS_PPRIV];
        end
    end

    // ****************************************
    // Unit status fields
    // ****************************************
    spcb_unit_status #(
        .HARDWIRED (FP_HARD)
    ) u_fp_status (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .op       (fp_op),
        .sw_we    (wr_en && hit_fp),
        .sw_val   (pwdata[1:0]),
        .status_r (fp_state_status),
        .exc      (fp_exc)
    );

    generate
        for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
            spcb_unit_status #(
                .HARDWIRED (EXT_HARD)
            ) u_ext_status (
                .pclk     (pclk),
                .presetn  (presetn),
                .ce       (ce),
                .op       (ext_op[3*g +: 3]),
                .sw_we    (wr_en && hit_ext),
                .sw_val   (pwdata[2*g +: 2]),
                .status_r (ext_st[g]),
                .exc      (ext_exc[g])
            );
        end
    endgenerate

    // Highest extension status
    always_comb begin
        agg_nxt = ST_OFF;
        for (int i = 0; i < NUM_EXT; i++) begin
            if (ext_st[i] > agg_nxt) begin
                agg_nxt = ext_st[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_state_aggregate <= ST_OFF;
            dirty_aggregate_bit <= 1'b0;
        end else if (ce) begin
            ext_state_aggregate <= agg_nxt;
            dirty_aggregate_bit <= (fp_state_status == ST_DIRTY) ||
                                   (agg_nxt == ST_DIRTY);
        end
    end

    // ****************************************
    // Memory access privilege and protection
    // ****************************************
    always_comb begin
        data_priv = modify_privilege_bit ? machine_previous_privilege : cur_priv;
        acc_priv  = (mem_kind == MEM_FETCH) ? cur_priv : data_priv;
        fault_nxt = 1'b0;
        if (vm_active) begin
            if ((mem_kind == MEM_LOAD) &&
                !(pte_read || (exec_readable_bit && pte_exec))) begin
                fault_nxt = 1'b1;
            end
            if ((mem_kind == MEM_STORE) && !pte_write) begin
                fault_nxt = 1'b1;
            end
            if ((mem_kind == MEM_FETCH) && !pte_exec) begin
                fault_nxt = 1'b1;
            end
            if ((acc_priv == PRIV_S) && pte_user &&
                !supervisor_user_access_bit) begin
                fault_nxt = 1'b1;
            end
            if ((acc_priv == PRIV_U) && !pte_user) begin
                fault_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_priv_r  <= PRIV_M;
            mem_fault_r <= 1'b0;
        end else if (ce) begin
            mem_priv_r  <= acc_priv;
            mem_fault_r <= mem_valid && fault_nxt;
        end
    end

    // ****************************************
    // Wait-for-interrupt timeout
    // ****************************************
    always_comb begin
        in_super  = (cur_priv == PRIV_S);
        wait_trap = wait_interrupt_pending && in_super && trap_wait_bit &&
                    !wait_fired_r && (wait_cnt_r == WAIT_MAX);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_r   <= '0;
            wait_fired_r <= 1'b0;
        end else if (ce) begin
            if (!(wait_interrupt_pending && in_super && trap_wait_bit)) begin
                wait_cnt_r   <= '0;
                wait_fired_r <= 1'b0;
            end else begin
                if (wait_cnt_r != WAIT_MAX) begin
                    wait_cnt_r <= wait_cnt_r + 1'b1;
                end
                if (wait_trap) begin
                    wait_fired_r <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Illegal instruction report
    // ****************************************
    always_comb begin
        illegal_nxt = wait_trap || fp_exc || (|ext_exc);
        if (instr_valid && in_super) begin
            if (trap_translation_ops_bit &&
                (is_xlat_reg_access || is_translation_fence_instr)) begin
                illegal_nxt = 1'b1;
            end
            if (trap_supervisor_return_bit && is_supervisor_return_instr) begin
                illegal_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            illegal_instr_r <= 1'b0;
        end else if (ce) begin
            illegal_instr_r <= illegal_nxt;
        end
    end

endmodule

// [verification/spcb_status_chk.sv]
// Purpose: Port assertions for the status control block.
// Assumes: One clock domain, reset active low.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/100ps
module spcb_status_chk
    import spcb_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ce,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic [1:0] cur_priv,
    input wire logic       mem_valid,
    input wire logic [1:0] mem_kind,
    input wire logic [1:0] mem_priv_r,
    input wire logic       instr_valid,
    input wire logic       is_xlat_reg_access,
    input wire logic       is_supervisor_return_instr,
    input wire logic       illegal_instr_r,
    input wire logic       modify_privilege_bit,
    input wire logic [1:0] machine_previous_privilege,
    input wire logic       trap_translation_ops_bit,
    input wire logic       trap_supervisor_return_bit,
    input wire logic [2:0] fp_op,
    input wire logic [1:0] fp_state_status,
    input wire logic [1:0] ext_state_aggregate,
    input wire logic       dirty_aggregate_bit
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("access ready wrong");
    property p_dpriv; ce && mem_valid && mem_kind != MEM_FETCH && modify_privilege_bit
        |=> mem_priv_r == $past(machine_previous_privilege); endproperty
    a_dpriv: assert property (p_dpriv) else $error("data privilege wrong");
    property p_fpriv; ce && mem_valid && mem_kind == MEM_FETCH
        |=> mem_priv_r == $past(cur_priv); endproperty
    a_fpriv: assert property (p_fpriv) else $error("fetch privilege wrong");
    property p_xlat; ce && instr_valid && is_xlat_reg_access && cur_priv == PRIV_S
        && trap_translation_ops_bit |=> illegal_instr_r; endproperty
    a_xlat: assert property (p_xlat) else $error("no translation trap");
    property p_supervisor_return_instr; ce && instr_valid && is_supervisor_return_instr && cur_priv == PRIV_S
        && trap_supervisor_return_bit |=> illegal_instr_r; endproperty
    a_supervisor_return_instr: assert property (p_supervisor_return_instr) else $error("no return trap");
    property p_offrd; ce && fp_op == UOP_READ && fp_state_status == ST_OFF
        |=> illegal_instr_r; endproperty
    a_offrd: assert property (p_offrd) else $error("no trap on off unit");
    property p_mod; ce && fp_op == UOP_MODIFY && fp_state_status != ST_OFF
        |=> fp_state_status == ST_DIRTY; endproperty
    a_mod: assert property (p_mod) else $error("modify not dirty");
    property p_sd; ce |=> dirty_aggregate_bit == ($past(fp_state_status) == ST_DIRTY
        || ext_state_aggregate == ST_DIRTY); endproperty
    a_sd: assert property (p_sd) else $error("dirty summary wrong");
    c_ill: cover property (illegal_instr_r);
    c_sd: cover property (dirty_aggregate_bit);
    c_modify_privilege_bit: cover property (mem_valid && modify_privilege_bit);
endmodule
bind spcb_status_ctrl spcb_status_chk spcb_status_chk_i (.pclk, .presetn, .ce, .psel,
    .penable, .pready, .cur_priv, .mem_valid, .mem_kind, .mem_priv_r, .instr_valid,
    .is_xlat_reg_access, .is_supervisor_return_instr, .illegal_instr_r, .modify_privilege_bit,
    .machine_previous_privilege, .trap_translation_ops_bit, .trap_supervisor_return_bit,
    .fp_op, .fp_state_status, .ext_state_aggregate, .dirty_aggregate_bit);

// [verification/spcb_status_ctrl_test.sv]
// Purpose: Self-checking bench for the status control block.
// Assumes: ce held high except for the last unit op; wait limit shortened to 2.
// Notes:   Each APB transfer ends with one idle cycle.
`timescale 1ns/100ps
module spcb_status_ctrl_test;
    import spcb_pkg::*;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, vm_active;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  cur_priv, mem_kind, mem_priv_r, machine_previous_privilege;
    logic [1:0]  fp_state_status, ext_state_aggregate;
    logic        mem_valid, pte_read, pte_write, pte_exec, pte_user, mem_fault_r;
    logic        instr_valid, is_xlat_reg_access, is_translation_fence_instr;
    logic        is_supervisor_return_instr, wait_interrupt_pending, illegal_instr_r;
    logic        modify_privilege_bit, exec_readable_bit, supervisor_user_access_bit;
    logic        trap_translation_ops_bit, trap_wait_bit, trap_supervisor_return_bit;
    logic        dirty_aggregate_bit, ill;
    logic [2:0]  fp_op;
    logic [5:0]  ext_op;
    logic [2:0]  ops [5] = '{UOP_ENABLE, UOP_MODIFY, UOP_UNCONF, UOP_MODIFY, UOP_DISABL};
    logic [1:0]  sts [5] = '{ST_INIT, ST_DIRTY, ST_INIT, ST_DIRTY, ST_OFF};
    int          mismatches = 0;
    int          checked = 0;
    spcb_status_ctrl #(.WAIT_LIMIT(2)) spcb_status_ctrl_i (.*);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic check(input logic [32:0] s, input logic [32:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int k = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
        {psel, penable} <= 2'b00;
        if (!w) check({pslverr, prdata}, e);
        if (k >= 20) mismatches++;
        @(posedge pclk);
    endtask
    task automatic mem(input logic [1:0] k, input logic [3:0] rwxu, input logic [2:0] e);
        {mem_valid, mem_kind, pte_read, pte_write, pte_exec, pte_user} <= {1'b1, k, rwxu};
        @(posedge pclk);
        mem_valid <= 1'b0;
        #1 check({mem_priv_r, mem_fault_r}, e);
        @(posedge pclk);
    endtask
    task automatic ins(input logic [2:0] v, input logic e);
        {instr_valid, is_xlat_reg_access, is_translation_fence_instr,
            is_supervisor_return_instr} <= {1'b1, v};
        @(posedge pclk);
        instr_valid <= 1'b0;
        #1 check(illegal_instr_r, e);
        @(posedge pclk);
    endtask
    task automatic uop(input logic [2:0] f, input logic [5:0] x, input logic [5:0] e);
        {fp_op, ext_op} <= {f, x};
        @(posedge pclk);
        {fp_op, ext_op} <= 9'h0;
        #1 ill = illegal_instr_r;
        @(posedge pclk);
        #1 check({dirty_aggregate_bit, ext_state_aggregate, ill, fp_state_status}, e);
        @(posedge pclk);
    endtask
    task automatic wt(input int e);
        int n = 0;
        wait_interrupt_pending <= 1'b1;
        repeat (8) begin
            @(posedge pclk);
            #1 n += int'(illegal_instr_r === 1'b1);
        end
        @(posedge pclk);
        wait_interrupt_pending <= 1'b0;
        check(n, e);
        @(posedge pclk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        apb(1'b0, OFF_CTRL, 32'h0, 33'h0);
        apb(1'b1, OFF_CTRL, 32'h33f, 33'h0);
        apb(1'b0, OFF_CTRL, 32'h0, 33'h33f);
        check({machine_previous_privilege, trap_supervisor_return_bit, trap_wait_bit,
            trap_translation_ops_bit, supervisor_user_access_bit, exec_readable_bit,
            modify_privilege_bit}, 8'hff);
        apb(1'b1, OFF_SUMM, 32'h8000_0003, 33'h0);
        apb(1'b0, OFF_SUMM, 32'h0, 33'h0);
        apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000);
    endtask
    task automatic t_access();
        cur_priv <= PRIV_M;
        apb(1'b1, OFF_CTRL, 32'h101, 33'h0);
        mem(MEM_STORE, 4'b0100, 3'b010);
        mem(MEM_FETCH, 4'b0010, 3'b110);
        vm_active <= 1'b1;
        mem(MEM_LOAD, 4'b1001, 3'b011);
        cur_priv <= PRIV_S;
        apb(1'b1, OFF_CTRL, 32'h0, 33'h0);
        mem(MEM_LOAD, 4'b0010, 3'b011);
        mem(MEM_FETCH, 4'b0011, 3'b011);
        apb(1'b1, OFF_CTRL, 32'h6, 33'h0);
        mem(MEM_LOAD, 4'b0011, 3'b010);
    endtask
    task automatic t_traps();
        apb(1'b1, OFF_CTRL, 32'h28, 33'h0);
        for (int i = 0; i < 3; i++) ins(3'b100 >> i, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h10, 33'h0);
        ins(3'b111, 1'b0);
        wt(1);
        apb(1'b1, OFF_CTRL, 32'h0, 33'h0);
        wt(0);
    endtask
    task automatic t_units();
        uop(UOP_READ, 6'h0, 6'h04);
        for (int i = 0; i < 5; i++) begin
            uop(ops[i], 6'h0, {sts[i] == ST_DIRTY, 3'b000, sts[i]});
        end
        apb(1'b1, OFF_FP, 32'h2, 33'h0);
        uop(UOP_MODIFY, 6'h0, 6'h23);
        apb(1'b0, OFF_SUMM, 32'h0, 33'h8000_0000);
        apb(1'b1, OFF_FP, 32'h2, 33'h0);
        apb(1'b1, OFF_EXT, 32'h6, 33'h0);
        uop(UOP_NONE, 6'h0, 6'h12);
        uop(UOP_NONE, {UOP_MODIFY, UOP_NONE}, 6'h3a);
        apb(1'b0, OFF_EXT, 32'h0, 33'he);
        apb(1'b0, OFF_SUMM, 32'h0, 33'h8000_0003);
        ce <= 1'b0;
        uop(UOP_MODIFY, 6'h0, 6'h3a);
        ce <= 1'b1;
    endtask
    task automatic end_sim();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, cur_priv, vm_active} = '0;
        {mem_valid, mem_kind, pte_read, pte_write, pte_exec, pte_user, instr_valid} = '0;
        {is_xlat_reg_access, is_translation_fence_instr, is_supervisor_return_instr} = '0;
        {wait_interrupt_pending, fp_op, ext_op} = '0;
        ce = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_access();
        t_traps();
        t_units();
        end_sim();
    end
    initial begin
        #8000 mismatches++;
        end_sim();
    end
endmodule
